// *** design/nested_irq_pkg.sv ***
// constants for the nested interrupt priority controller
package nested_irq_pkg;
    // ---------------------------------------------------------------
    // register map (word index on the plain register port)
    // ---------------------------------------------------------------
    localparam logic [2:0] ADDR_PRIO_0 = 3'h0;
    localparam logic [2:0] ADDR_PRIO_1 = 3'h1;
    localparam logic [2:0] ADDR_PRIO_2 = 3'h2;
    localparam logic [2:0] ADDR_PRIO_3 = 3'h3;
    localparam logic [2:0] ADDR_SENSE = 3'h4;
    localparam logic [7:0] PRIO_RESET = 8'hff;
    localparam logic [7:0] SENSE_RESET = 8'h00;
    localparam logic [7:0] PRIO3_RO_MASK = 8'hf0;
    // ---------------------------------------------------------------
    // sensitivity register fields
    // ---------------------------------------------------------------
    localparam int PORTB_SENSE_HI = 7;
    localparam int PORTB_SENSE_LO = 6;
    localparam int PORTB_INV_BIT = 5;
    localparam int PORTA_SENSE_HI = 4;
    localparam int PORTA_SENSE_LO = 3;
    localparam int PORTA_INV_BIT = 2;
    localparam logic [7:0] SENSE_WRITE_MASK = 8'hfc;
    // ---------------------------------------------------------------
    // priority level and pin sense codes
    // ---------------------------------------------------------------
    localparam logic [1:0] LEVEL_0 = 2'h2;
    localparam logic [1:0] LEVEL_1 = 2'h1;
    localparam logic [1:0] LEVEL_2 = 2'h0;
    localparam logic [1:0] LEVEL_3 = 2'h3;
    localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
    localparam logic [1:0] SENSE_RISE = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;
    // ---------------------------------------------------------------
    // vectors
    // ---------------------------------------------------------------
    localparam int NUM_VEC = 14;
    localparam logic [15:0] VEC_RESET_ADDR = 16'hfffe;
    localparam logic [15:0] VEC_TRAP_ADDR = 16'hfffc;
    localparam logic [15:0] VEC_0_ADDR = 16'hfffa;
    localparam int VEC_TIME_BASE = 1;
    localparam int VEC_PORTA = 2;
    localparam int VEC_PORTF = 3;
    localparam int VEC_PORTB_LOW = 4;
    localparam int VEC_PORTB_HIGH = 5;
    localparam int VEC_SPI = 7;
    localparam logic [13:0] HALT_WAKE_MASK = 14'h00bc;
    localparam logic [13:0] ACTIVE_HALT_WAKE_MASK = 14'h0002;
    // cpu instruction codes on the instruction event port
    typedef enum logic [2:0] {
        INSTR_NONE = 3'b000,
        INSTR_ENABLE = 3'b001,
        INSTR_DISABLE = 3'b010,
        INSTR_TRAP = 3'b011,
        INSTR_HALT = 3'b100,
        INSTR_WAIT = 3'b101,
        INSTR_POP_CC = 3'b110,
        INSTR_RETURN = 3'b111
    } instr_type;
endpackage : nested_irq_pkg

// *** design/nested_irq_priority_ctrl.sv ***
// nested interrupt priority controller: priorities, arbitration, pin sensing
module nested_irq_priority_ctrl (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire logic [2:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    input wire logic [13:0] I_PERIPH_REQ,
    input wire logic [13:0] I_VEC_ENABLE,
    input wire logic [3:0] I_PORTA_PINS,
    input wire logic [2:0] I_PORTF_PINS,
    input wire logic [3:0] I_PORTB_LOW_PINS,
    input wire logic I_PORTB_HIGH_PIN,
    input wire logic [2:0] I_INSTR,
    input wire logic [7:0] I_POP_CC,
    input wire logic I_ACK,
    input wire logic I_HALT_MODE,
    input wire logic I_ACTIVE_HALT_MODE,
    output logic O_IRQ,
    output logic [3:0] O_IRQ_VEC,
    output logic [15:0] O_IRQ_ADDR,
    output logic [7:0] O_CC_LEVEL_BITS,
    output logic [1:0] O_RUN_LEVEL,
    output logic O_JUMP_IF_MASKED,
    output logic O_JUMP_IF_UNMASKED,
    output logic O_WAKE
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [7:0] vector_priority_regs [4];
    logic [7:0] pin_irq_sensitivity;
    logic run_level_hi;
    logic run_level_lo;
    logic [13:0] pending;
    logic [3:0] porta_prev;
    logic [2:0] portf_prev;
    logic [3:0] portb_low_prev;
    logic portb_high_prev;
    logic [13:0] pin_req;
    logic [13:0] eligible;
    logic [13:0] wake_mask;
    logic [2:0] rank_run;
    logic found;
    logic [3:0] best_vec;
    logic [2:0] best_rank;
    logic sense_wr_ok;
    logic sense_changed;
    logic [7:0] next_sense;
    logic [7:0] next_prio;
    logic [1:0] vec_prio [nested_irq_pkg::NUM_VEC];
    // pin group vector numbers, short local names for the sensing loop
    localparam int VEC_PA = nested_irq_pkg::VEC_PORTA;
    localparam int VEC_PF = nested_irq_pkg::VEC_PORTF;
    localparam int VEC_PBL = nested_irq_pkg::VEC_PORTB_LOW;
    localparam int VEC_PBH = nested_irq_pkg::VEC_PORTB_HIGH;
    typedef nested_irq_pkg::instr_type instr_type;

    // level code to rank 0..3, so comparisons are plain magnitude
    function automatic logic [2:0] rank(input logic [1:0] code);
        unique case (code)
            nested_irq_pkg::LEVEL_0: rank = 3'h0;
            nested_irq_pkg::LEVEL_1: rank = 3'h1;
            nested_irq_pkg::LEVEL_2: rank = 3'h2;
            default: rank = 3'h3;
        endcase
    endfunction : rank

    // one pin against a sense code; level terms use the present sample
    function automatic logic sense(input logic cur, input logic prv, input logic [1:0] mode,
                                   input logic inv, input logic can_inv);
        logic c;
        logic p;
        logic hit;
        c = (inv && can_inv && mode != nested_irq_pkg::SENSE_BOTH) ? ~cur : cur;
        p = (inv && can_inv && mode != nested_irq_pkg::SENSE_BOTH) ? ~prv : prv;
        unique case (mode)
            nested_irq_pkg::SENSE_FALL_LOW: hit = ~c;
            nested_irq_pkg::SENSE_RISE: hit = c & ~p;
            nested_irq_pkg::SENSE_FALL: hit = ~c & p;
            default: hit = c ^ p;
        endcase
        sense = hit;
    endfunction : sense

    // ---------------------------------------------------------------
    // priority pairs and sensing
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < nested_irq_pkg::NUM_VEC; g++) begin : g_vec
            assign vec_prio[g] = vector_priority_regs[g / 4][(g % 4) * 2 +: 2];
        end
    endgenerate

    // pin events per group, pins in a group are ORed
    always_comb begin
        logic [1:0] bsense;
        logic [1:0] asense;
        bsense = pin_irq_sensitivity[nested_irq_pkg::PORTB_SENSE_HI:nested_irq_pkg::PORTB_SENSE_LO];
        asense = pin_irq_sensitivity[nested_irq_pkg::PORTA_SENSE_HI:nested_irq_pkg::PORTA_SENSE_LO];
        pin_req = '0;
        for (int i = 0; i < 4; i++) begin
            pin_req[VEC_PA] |= sense(I_PORTA_PINS[i], porta_prev[i], asense,
                pin_irq_sensitivity[nested_irq_pkg::PORTA_INV_BIT], 1'b1);
            pin_req[VEC_PBL] |= sense(I_PORTB_LOW_PINS[i], portb_low_prev[i], bsense,
                pin_irq_sensitivity[nested_irq_pkg::PORTB_INV_BIT], 1'b1);
        end
        for (int i = 0; i < 3; i++) begin
            pin_req[VEC_PF] |= sense(I_PORTF_PINS[i], portf_prev[i], asense, 1'b0, 1'b0);
        end
        pin_req[VEC_PBH] = sense(I_PORTB_HIGH_PIN, portb_high_prev, bsense, 1'b0, 1'b0);
    end

    // ---------------------------------------------------------------
    // arbitration
    // ---------------------------------------------------------------
    // wake sources restrict the first choice out of a low power mode
    always_comb begin
        if (I_ACTIVE_HALT_MODE) begin
            wake_mask = nested_irq_pkg::ACTIVE_HALT_WAKE_MASK;
        end else if (I_HALT_MODE) begin
            wake_mask = nested_irq_pkg::HALT_WAKE_MASK;
        end else begin
            wake_mask = '1;
        end
    end

    assign rank_run = rank({run_level_hi, run_level_lo});
    // highest software rank wins, ties go to the lowest vector number
    always_comb begin
        found = 1'b0;
        best_vec = 4'h0;
        best_rank = 3'h0;
        for (int v = 0; v < nested_irq_pkg::NUM_VEC; v++) begin
            eligible[v] = pending[v] && I_VEC_ENABLE[v] && wake_mask[v]
                && (rank(vec_prio[v]) > rank_run);
            if (eligible[v] && (!found || rank(vec_prio[v]) > best_rank)) begin
                found = 1'b1;
                best_vec = 4'(v);
                best_rank = rank(vec_prio[v]);
            end
        end
    end

    assign O_IRQ = found;
    assign O_IRQ_VEC = best_vec;
    assign O_IRQ_ADDR = nested_irq_pkg::VEC_0_ADDR - {11'h000, best_vec, 1'b0};
    assign O_WAKE = |(pending & I_VEC_ENABLE & wake_mask);
    assign O_RUN_LEVEL = {run_level_hi, run_level_lo};
    assign O_CC_LEVEL_BITS = {2'h0, run_level_hi, 1'b0, run_level_lo, 3'h0};
    assign O_JUMP_IF_MASKED = ({run_level_hi, run_level_lo} == nested_irq_pkg::LEVEL_3);
    assign O_JUMP_IF_UNMASKED = ({run_level_hi, run_level_lo} != nested_irq_pkg::LEVEL_3);

    // ---------------------------------------------------------------
    // running level
    // ---------------------------------------------------------------
    // the pop and return load bits 5 and 3 of the stacked byte; entry loads the pair
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            {run_level_hi, run_level_lo} <= nested_irq_pkg::LEVEL_3;
        end else if (I_ACK && found) begin
            {run_level_hi, run_level_lo} <= vec_prio[best_vec];
        end else begin
            unique case (instr_type'(I_INSTR))
                nested_irq_pkg::INSTR_ENABLE, nested_irq_pkg::INSTR_HALT,
                nested_irq_pkg::INSTR_WAIT: begin
                    {run_level_hi, run_level_lo} <= nested_irq_pkg::LEVEL_0;
                end
                nested_irq_pkg::INSTR_DISABLE, nested_irq_pkg::INSTR_TRAP: begin
                    {run_level_hi, run_level_lo} <= nested_irq_pkg::LEVEL_3;
                end
                nested_irq_pkg::INSTR_POP_CC, nested_irq_pkg::INSTR_RETURN: begin
                    {run_level_hi, run_level_lo} <= {I_POP_CC[5], I_POP_CC[3]};
                end
                default: begin
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // pending latches
    // ---------------------------------------------------------------
    assign sense_wr_ok = I_WR && (I_ADDR == nested_irq_pkg::ADDR_SENSE)
        && ({run_level_hi, run_level_lo} == nested_irq_pkg::LEVEL_3);
    assign next_sense = (I_WDATA & nested_irq_pkg::SENSE_WRITE_MASK);
    assign sense_changed = sense_wr_ok && (next_sense != pin_irq_sensitivity);

    // serviced request cleared on ack; new events win over the clear
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            pending <= '0;
        end else begin
            for (int v = 0; v < nested_irq_pkg::NUM_VEC; v++) begin
                if (I_PERIPH_REQ[v] || pin_req[v]) begin
                    pending[v] <= 1'b1;
                end else if (I_ACK && found && best_vec == 4'(v)) begin
                    pending[v] <= 1'b0;
                end else if (sense_changed && v >= VEC_PA && v <= VEC_PBH) begin
                    pending[v] <= 1'b0;
                end
            end
        end
    end

    // previous pin samples for edge detection
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            porta_prev <= '1;
            portf_prev <= '1;
            portb_low_prev <= '1;
            portb_high_prev <= 1'b1;
        end else begin
            porta_prev <= I_PORTA_PINS;
            portf_prev <= I_PORTF_PINS;
            portb_low_prev <= I_PORTB_LOW_PINS;
            portb_high_prev <= I_PORTB_HIGH_PIN;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    // level-0 code is refused pair by pair
    always_comb begin
        next_prio = vector_priority_regs[I_ADDR[1:0]];
        for (int p = 0; p < 4; p++) begin
            if (I_WDATA[p * 2 +: 2] != nested_irq_pkg::LEVEL_0) begin
                next_prio[p * 2 +: 2] = I_WDATA[p * 2 +: 2];
            end
        end
        if (I_ADDR == nested_irq_pkg::ADDR_PRIO_3) begin
            next_prio = next_prio | nested_irq_pkg::PRIO3_RO_MASK;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            for (int r = 0; r < 4; r++) begin
                vector_priority_regs[r] <= nested_irq_pkg::PRIO_RESET;
            end
        end else if (I_WR && I_ADDR <= nested_irq_pkg::ADDR_PRIO_3) begin
            vector_priority_regs[I_ADDR[1:0]] <= next_prio;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            pin_irq_sensitivity <= nested_irq_pkg::SENSE_RESET;
        end else if (sense_wr_ok) begin
            pin_irq_sensitivity <= next_sense;
        end
    end

    // read data stands one cycle after the strobe; unmapped reads zero
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            O_RDATA <= 8'h00;
        end else if (I_RD && I_ADDR <= nested_irq_pkg::ADDR_PRIO_3) begin
            O_RDATA <= vector_priority_regs[I_ADDR[1:0]];
        end else if (I_RD && I_ADDR == nested_irq_pkg::ADDR_SENSE) begin
            O_RDATA <= pin_irq_sensitivity;
        end else begin
            O_RDATA <= 8'h00;
        end
    end
endmodule : nested_irq_priority_ctrl

// *** test/irq_ctrl_checker_sva.sv ***
// assertion checker for the nested interrupt priority controller
// ---------------------------------------------------------------
// checker
// ---------------------------------------------------------------
module irq_ctrl_checker (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire logic [2:0] I_ADDR,
    input wire logic I_RD,
    input wire logic [7:0] O_RDATA,
    input wire logic [2:0] I_INSTR,
    input wire logic [7:0] I_POP_CC,
    input wire logic I_ACK,
    input wire logic O_IRQ,
    input wire logic [3:0] O_IRQ_VEC,
    input wire logic [15:0] O_IRQ_ADDR,
    input wire logic [7:0] O_CC_LEVEL_BITS,
    input wire logic [1:0] O_RUN_LEVEL,
    input wire logic O_JUMP_IF_MASKED,
    input wire logic O_JUMP_IF_UNMASKED
);
    logic [1:0] pop_level;
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    // stacked level bits; an ack while an interrupt is offered outranks any instruction in the same cycle
    assign pop_level = {I_POP_CC[5], I_POP_CC[3]};
    enable_load_a: assert property (I_INSTR == 3'h1 && !I_ACK |=> O_RUN_LEVEL == 2'h2)
        else $error("enable did not load level 0");
    mask_load_a: assert property (I_INSTR inside {3'h2, 3'h3} && !I_ACK |=> O_RUN_LEVEL == 2'h3)
        else $error("disable or trap did not load level 3");
    sleep_load_a: assert property (I_INSTR inside {3'h4, 3'h5} && !I_ACK |=> O_RUN_LEVEL == 2'h2)
        else $error("halt or wait did not load level 0");
    pop_restore_a: assert property (I_INSTR inside {3'h6, 3'h7} && !I_ACK
        |=> O_RUN_LEVEL == $past(pop_level))
        else $error("pop did not restore the level bits");
    jump_pair_a: assert property (O_JUMP_IF_MASKED == (O_RUN_LEVEL == 2'h3)
        && O_JUMP_IF_UNMASKED != O_JUMP_IF_MASKED)
        else $error("jump conditions disagree with level");
    cc_mirror_a: assert property (O_CC_LEVEL_BITS[5] == O_RUN_LEVEL[1]
        && O_CC_LEVEL_BITS[3] == O_RUN_LEVEL[0])
        else $error("cc level bits differ from level");
    masked_quiet_a: assert property (O_IRQ |-> O_RUN_LEVEL != 2'h3)
        else $error("interrupt offered at level 3");
    vec_addr_a: assert property (O_IRQ |-> O_IRQ_ADDR == 16'hfffa - {11'h000, O_IRQ_VEC, 1'b0})
        else $error("vector address wrong");
    prio3_top_a: assert property (I_RD && I_ADDR == 3'h3 |=> O_RDATA[7:4] == 4'hf)
        else $error("upper nibble of priority 3 not ones");
    reset_level_a: assert property ($rose(I_RST_N) |-> O_RUN_LEVEL == 2'h3)
        else $error("level not 3 after reset");
    cover property (O_IRQ && I_ACK);
    cover property (O_JUMP_IF_MASKED ##1 O_JUMP_IF_UNMASKED);
    cover property (I_RD ##1 O_RDATA != 8'h00);
endmodule : irq_ctrl_checker

bind nested_irq_priority_ctrl irq_ctrl_checker u_chk (.I_CORE_CLK, .I_RST_N, .I_ADDR, .I_RD,
    .O_RDATA, .I_INSTR, .I_POP_CC, .I_ACK, .O_IRQ, .O_IRQ_VEC, .O_IRQ_ADDR, .O_CC_LEVEL_BITS,
    .O_RUN_LEVEL, .O_JUMP_IF_MASKED, .O_JUMP_IF_UNMASKED);

// *** test/irq_cpu_model.sv ***
// cpu side model that takes an offered interrupt after a set delay
// ---------------------------------------------------------------
// acknowledger
// ---------------------------------------------------------------
module irq_cpu_model #(
    parameter int DELAY = 2
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_go,
    input wire logic i_irq,
    output logic o_ack
);
    int cnt;
    // one pulse per take; a slow cpu lets the offer stand a while first
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !i_go || !i_irq || o_ack) begin
            o_ack <= 1'b0;
            cnt <= 0;
        end else if (cnt >= DELAY) begin
            o_ack <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : irq_cpu_model

// *** test/nested_irq_priority_ctrl_bench.sv ***
// self-checking bench for the nested interrupt priority controller
module nested_irq_priority_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, halt = 1'b0, go = 1'b0;
    logic ack, irq, jm, jnm, wake;
    logic [2:0] addr = 3'h0, instr = 3'h0;
    logic [7:0] wdata = 8'h00, pop_cc = 8'h00, rdata, cc_bits;
    logic [13:0] req = 14'h0000, ven = 14'h0000;
    logic [3:0] pb_low = 4'hf, vec;
    logic [15:0] vaddr;
    logic [1:0] level;
    int fails = 0, num_checks = 0, cycles = 0;
    // ---------------------------------------------------------------
    // clock, dut and cpu model
    // ---------------------------------------------------------------
    always #2 clk = ~clk;
    nested_irq_priority_ctrl u_dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_PERIPH_REQ(req),
        .I_VEC_ENABLE(ven), .I_PORTA_PINS(4'hf), .I_PORTF_PINS(3'h7), .I_PORTB_LOW_PINS(pb_low),
        .I_PORTB_HIGH_PIN(1'b1), .I_INSTR(instr), .I_POP_CC(pop_cc), .I_ACK(ack),
        .I_HALT_MODE(halt), .I_ACTIVE_HALT_MODE(1'b0), .O_IRQ(irq), .O_IRQ_VEC(vec),
        .O_IRQ_ADDR(vaddr), .O_CC_LEVEL_BITS(cc_bits), .O_RUN_LEVEL(level),
        .O_JUMP_IF_MASKED(jm), .O_JUMP_IF_UNMASKED(jnm), .O_WAKE(wake));
    irq_cpu_model #(.DELAY(2)) u_cpu (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_irq(irq),
        .o_ack(ack));
    // ---------------------------------------------------------------
    // helpers: every task but chk drives after a rising edge, ends at a falling one
    // ---------------------------------------------------------------
    task automatic chk(input logic [15:0] s, input logic [15:0] e, input string n);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask : wreg
    task automatic rreg(input logic [2:0] a, input logic [7:0] e, input string n);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e, n);
    endtask : rreg
    task automatic do_instr(input logic [2:0] c, input logic [7:0] p);
        @(posedge clk);
        instr <= c;
        pop_cc <= p;
        @(posedge clk);
        instr <= 3'h0;
        @(negedge clk);
    endtask : do_instr
    // cpu takes the offer; bounded wait for its acknowledge
    task automatic take(input logic [1:0] e, input string n);
        @(posedge clk);
        go <= 1'b1;
        for (int i = 0; i < 20 && !ack; i++) @(posedge clk);
        go <= 1'b0;
        @(negedge clk);
        chk(level, e, n);
    endtask : take
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_regs();
        for (int i = 0; i < 4; i++) rreg(i[2:0], 8'hff, "priority reset");
        rreg(3'h4, 8'h00, "sense reset");
        wreg(3'h0, 8'hcf);
        wreg(3'h0, 8'h64);
        rreg(3'h0, 8'h44, "level 0 code refused");
        wreg(3'h3, 8'h00);
        rreg(3'h3, 8'hf0, "priority 3 upper bits");
        wreg(3'h4, 8'hf8);
        rreg(3'h4, 8'hf8, "sense at level 3");
        do_instr(3'h1, 8'h00);
        chk(jnm, 1'b1, "unmasked jump");
        wreg(3'h4, 8'h00);
        rreg(3'h4, 8'hf8, "sense locked");
        do_instr(3'h2, 8'h00);
        chk(jm, 1'b1, "masked jump");
        do_instr(3'h4, 8'h00);
        chk(level, 2'h2, "halt level");
        do_instr(3'h3, 8'h00);
        chk(level, 2'h3, "trap level");
        do_instr(3'h5, 8'h00);
        chk(level, 2'h2, "wait level");
        do_instr(3'h6, 8'h08);
        chk(level, 2'h1, "pop level");
        do_instr(3'h2, 8'h00);
        wreg(3'h4, 8'h00);
        rreg(3'h4, 8'h00, "sense cleared");
        $display("register test done");
    endtask : t_regs
    task automatic t_arb();
        wreg(3'h2, 8'hfd);
        @(posedge clk);
        ven <= 14'h0300;
        req <= 14'h0300;
        @(posedge clk);
        req <= 14'h0000;
        do_instr(3'h1, 8'h00);
        chk(vec, 4'h9, "higher soft priority wins");
        chk(vaddr, 16'hffe8, "vector 9 address");
        take(2'h3, "level of vector 9");
        chk(irq, 1'b0, "lower request held");
        do_instr(3'h7, 8'h20);
        chk(vec, 4'h8, "pending served after return");
        chk(vaddr, 16'hffea, "vector 8 address");
        take(2'h1, "level of vector 8");
        do_instr(3'h2, 8'h00);
        $display("arbitration test done");
    endtask : t_arb
    task automatic t_pin();
        wreg(3'h4, 8'h60);
        @(posedge clk);
        ven <= 14'h0010;
        pb_low <= 4'he;
        halt <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(wake, 1'b1, "pin wakes halt");
        do_instr(3'h1, 8'h00);
        chk(vec, 4'h4, "inverted rise senses fall");
        chk(vaddr, 16'hfff2, "vector 4 address");
        do_instr(3'h2, 8'h00);
        @(posedge clk);
        pb_low <= 4'hf;
        wreg(3'h4, 8'h40);
        @(posedge clk);
        pb_low <= 4'he;
        req <= 14'h0100;
        ven <= 14'h0110;
        @(posedge clk);
        req <= 14'h0000;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(wake, 1'b0, "timer and cleared pin keep halt");
        // leave halt first: only wake sources may be chosen while halted
        @(posedge clk);
        halt <= 1'b0;
        do_instr(3'h1, 8'h00);
        chk(vec, 4'h8, "pin pending cleared, fall ignored");
        do_instr(3'h2, 8'h00);
        $display("pin test done");
    endtask : t_pin
    // ---------------------------------------------------------------
    // verdict, timeout and main sequence
    // ---------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    // whole run needs about a hundred cycles; a hang stops well after that
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            results();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_arb();
        t_pin();
        results();
    end
endmodule : nested_irq_priority_ctrl_bench
